// ==== src/cmpctl_pkg.sv ====
/*
  Package for the comparator control logic: register addresses, field
  positions, reset values and carrier structs.
  Assumes an 8-bit special-function register port with an 8-bit address.
*/
package cmpctl_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CMPCTL_ADDR_CONTROL = 8'h9b;
  localparam logic [7:0] CMPCTL_ADDR_MODE = 8'h9d;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CMPCTL_BIT_ON = 7;
  localparam int CMPCTL_BIT_RESULT = 6;
  localparam int CMPCTL_BIT_RISE = 5;
  localparam int CMPCTL_BIT_FALL = 4;
  localparam int CMPCTL_POS_HI = 3;
  localparam int CMPCTL_POS_LO = 2;
  localparam int CMPCTL_NEG_HI = 1;
  localparam int CMPCTL_NEG_LO = 0;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int CMPCTL_BIT_RISE_MASK = 5;
  localparam int CMPCTL_BIT_FALL_MASK = 4;
  localparam int CMPCTL_SPEED_HI = 1;
  localparam int CMPCTL_SPEED_LO = 0;

  // Hysteresis codes: off, 5 mV, 10 mV, 20 mV
  localparam logic [1:0] CMPCTL_HYST_OFF = 2'h0;
  localparam logic [1:0] CMPCTL_HYST_5MV = 2'h1;
  localparam logic [1:0] CMPCTL_HYST_10MV = 2'h2;
  localparam logic [1:0] CMPCTL_HYST_20MV = 2'h3;

  // Response speed codes, mode 0 fastest to mode 3 slowest
  localparam logic [1:0] CMPCTL_SPEED_RESET = 2'h2;

  localparam logic [7:0] CMPCTL_ZERO_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pos_hyst_sel;
    logic [1:0] neg_hyst_sel;
    logic [1:0] response_speed_sel;
    logic power_on;
  } cmpctl_analog_t;

  typedef struct packed {
    logic irq;
    logic reset_req;
    logic kill_trig;
  } cmpctl_event_t;

endpackage

// ==== src/cmpctl_sync.sv ====
/*
  Two-stage synchroniser for one level signal.
  Assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/1ps
module cmpctl_sync (
  input wire logic clk, // Sampling clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic din, // Asynchronous level
  output logic dout // Synchronised level
);

  logic stage1;

  // Only the second stage reads the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// ==== src/cmpctl_top.sv ====
/*
  Comparator control logic: control and mode registers on the special
  function register port, edge flags, interrupt request, latched and raw
  outputs, reset request and channel-kill trigger.
  The analog comparator, its input multiplexer and the pin crossbar sit
  outside; this block only drives their control levels and gates the
  result that they see.
  Assumes the core reads and writes whole bytes; unused bits read zero
  and ignore writes.
  Assumes the analog comparator drives CMP_RAW asynchronously and the core
  gives single-cycle read and write strobes with a stable address.
*/
`timescale 1ns/1ps
module cmpctl_top (
  input wire logic CLK, // System clock, 200 MHz
  input wire logic RST, // Asynchronous reset, active high
  input wire logic [7:0] SFR_ADDR, // Register address
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic SFR_WE, // Write strobe, one cycle
  input wire logic SFR_RE, // Read strobe, one cycle
  output logic [7:0] SFR_RDATA, // Read data, registered
  output logic SFR_HIT, // Address selects this block
  input wire logic CMP_RAW, // Analog comparison result
  output logic LATCHED_CMP_OUT, // Synchronous output to crossbar
  output logic RAW_CMP_OUT, // Asynchronous output to crossbar
  output logic [1:0] POS_HYST_SEL, // Positive hysteresis control
  output logic [1:0] NEG_HYST_SEL, // Negative hysteresis control
  output logic [1:0] RESPONSE_SPEED_SEL, // Response mode control
  output logic CMP_POWER_EN, // Analog power enable
  output logic CMP_IRQ, // Interrupt request, level
  output logic CMP_RESET_REQ, // Reset request source, level
  output logic CMP_KILL_TRIG // Counter channel kill trigger, level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic comparator_on;
  logic rise_seen_flag;
  logic fall_seen_flag;
  logic [1:0] pos_hyst_sel;
  logic [1:0] neg_hyst_sel;
  logic rise_irq_mask;
  logic fall_irq_mask;
  logic [1:0] response_speed_sel;
  logic cmp_sync;
  logic cmp_prev;
  logic compare_result;
  logic rise_evt;
  logic fall_evt;
  logic ctrl_wr;
  logic mode_wr;
  logic ctrl_sel;
  logic mode_sel;
  logic next_rise_seen_flag;
  logic next_fall_seen_flag;
  logic rise_irq;
  logic fall_irq;
  logic [7:0] ctrl_word;
  logic [7:0] mode_word;
  logic [7:0] next_rdata;
  cmpctl_pkg::cmpctl_analog_t analog;
  cmpctl_pkg::cmpctl_event_t evt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Register selects, decoded once and shared by write and read paths
  assign ctrl_sel = (SFR_ADDR == cmpctl_pkg::CMPCTL_ADDR_CONTROL);
  assign mode_sel = (SFR_ADDR == cmpctl_pkg::CMPCTL_ADDR_MODE);

  // Write strobes per register
  assign ctrl_wr = SFR_WE && ctrl_sel;
  assign mode_wr = SFR_WE && mode_sel;

  // Hit flag lets the core's bus mux pick this block's read data
  assign SFR_HIT = ctrl_sel || mode_sel;

  // ---------------------------------------------------------------
  // Result synchronisation and edge detection
  // ---------------------------------------------------------------
  // Raw result is asynchronous; never sample it directly
  cmpctl_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .din(CMP_RAW),
    .dout(cmp_sync)
  );

  // Previous synchronised value for edge detection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmp_prev <= 1'b0;
    end else begin
      cmp_prev <= cmp_sync;
    end
  end

  // Gated by enable so a powered-down comparator reads low
  assign compare_result = cmp_sync && comparator_on;
  assign rise_evt = comparator_on && cmp_sync && !cmp_prev;
  assign fall_evt = comparator_on && !cmp_sync && cmp_prev;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Enable bit; also powers the analog stage
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      comparator_on <= 1'b0;
    end else if (ctrl_wr) begin
      comparator_on <= SFR_WDATA[cmpctl_pkg::CMPCTL_BIT_ON];
    end
  end

  // Positive hysteresis; a change may flag a false edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pos_hyst_sel <= cmpctl_pkg::CMPCTL_HYST_OFF;
    end else if (ctrl_wr) begin
      pos_hyst_sel <= SFR_WDATA[cmpctl_pkg::CMPCTL_POS_HI:cmpctl_pkg::CMPCTL_POS_LO];
    end
  end

  // Negative hysteresis; same hazard as the positive side
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      neg_hyst_sel <= cmpctl_pkg::CMPCTL_HYST_OFF;
    end else if (ctrl_wr) begin
      neg_hyst_sel <= SFR_WDATA[cmpctl_pkg::CMPCTL_NEG_HI:cmpctl_pkg::CMPCTL_NEG_LO];
    end
  end

  // Next rising flag: a write loads it, a detected edge overrides the write
  always_comb begin
    next_rise_seen_flag = rise_seen_flag; // hardware never clears
    if (ctrl_wr) begin
      next_rise_seen_flag = SFR_WDATA[cmpctl_pkg::CMPCTL_BIT_RISE];
    end
    if (rise_evt) begin
      next_rise_seen_flag = 1'b1;
    end
  end

  // Rising flag register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rise_seen_flag <= 1'b0;
    end else begin
      rise_seen_flag <= next_rise_seen_flag;
    end
  end

  // Next falling flag: same priority, so no edge is lost to a clear
  always_comb begin
    next_fall_seen_flag = fall_seen_flag; // hardware never clears
    if (ctrl_wr) begin
      next_fall_seen_flag = SFR_WDATA[cmpctl_pkg::CMPCTL_BIT_FALL];
    end
    if (fall_evt) begin
      next_fall_seen_flag = 1'b1;
    end
  end

  // Falling flag register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fall_seen_flag <= 1'b0;
    end else begin
      fall_seen_flag <= next_fall_seen_flag;
    end
  end

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  // Rising mask; unused mode bits are not stored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rise_irq_mask <= 1'b0;
    end else if (mode_wr) begin
      rise_irq_mask <= SFR_WDATA[cmpctl_pkg::CMPCTL_BIT_RISE_MASK];
    end
  end

  // Falling mask
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fall_irq_mask <= 1'b0;
    end else if (mode_wr) begin
      fall_irq_mask <= SFR_WDATA[cmpctl_pkg::CMPCTL_BIT_FALL_MASK];
    end
  end

  // Response speed; slower modes trade reaction time for current
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      response_speed_sel <= cmpctl_pkg::CMPCTL_SPEED_RESET;
    end else if (mode_wr) begin
      response_speed_sel <= SFR_WDATA[cmpctl_pkg::CMPCTL_SPEED_HI:cmpctl_pkg::CMPCTL_SPEED_LO];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Control word as the core sees it; result bit is live, not stored
  always_comb begin
    ctrl_word = cmpctl_pkg::CMPCTL_ZERO_BYTE;
    ctrl_word[cmpctl_pkg::CMPCTL_BIT_ON] = comparator_on;
    ctrl_word[cmpctl_pkg::CMPCTL_BIT_RESULT] = compare_result;
    ctrl_word[cmpctl_pkg::CMPCTL_BIT_RISE] = rise_seen_flag;
    ctrl_word[cmpctl_pkg::CMPCTL_BIT_FALL] = fall_seen_flag;
    ctrl_word[cmpctl_pkg::CMPCTL_POS_HI:cmpctl_pkg::CMPCTL_POS_LO] = pos_hyst_sel;
    ctrl_word[cmpctl_pkg::CMPCTL_NEG_HI:cmpctl_pkg::CMPCTL_NEG_LO] = neg_hyst_sel;
  end

  // Mode word; unused bits stay zero
  always_comb begin
    mode_word = cmpctl_pkg::CMPCTL_ZERO_BYTE;
    mode_word[cmpctl_pkg::CMPCTL_BIT_RISE_MASK] = rise_irq_mask;
    mode_word[cmpctl_pkg::CMPCTL_BIT_FALL_MASK] = fall_irq_mask;
    mode_word[cmpctl_pkg::CMPCTL_SPEED_HI:cmpctl_pkg::CMPCTL_SPEED_LO] = response_speed_sel;
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_rdata = cmpctl_pkg::CMPCTL_ZERO_BYTE;
    if (ctrl_sel) begin
      next_rdata = ctrl_word;
    end else if (mode_sel) begin
      next_rdata = mode_word;
    end
  end

  // Read data captured on the read strobe, held until the next read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= cmpctl_pkg::CMPCTL_ZERO_BYTE;
    end else if (SFR_RE) begin
      SFR_RDATA <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to analog and system
  // ---------------------------------------------------------------
  // Analog controls gathered in one carrier
  always_comb begin
    analog.pos_hyst_sel = pos_hyst_sel;
    analog.neg_hyst_sel = neg_hyst_sel;
    analog.response_speed_sel = response_speed_sel;
    analog.power_on = comparator_on;
  end

  assign POS_HYST_SEL = analog.pos_hyst_sel;
  assign NEG_HYST_SEL = analog.neg_hyst_sel;
  assign RESPONSE_SPEED_SEL = analog.response_speed_sel;
  assign CMP_POWER_EN = analog.power_on;

  // Latched output from flops; low while disabled
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LATCHED_CMP_OUT <= 1'b0;
    end else begin
      LATCHED_CMP_OUT <= compare_result;
    end
  end

  // Raw path has no flop so it keeps working with the clock stopped
  assign RAW_CMP_OUT = CMP_RAW && comparator_on;

  // Per-edge requests, each gated by its own mask
  assign rise_irq = rise_seen_flag && rise_irq_mask;
  assign fall_irq = fall_seen_flag && fall_irq_mask;

  // Event outputs; reset and kill use the synchronised result
  always_comb begin
    evt.irq = rise_irq || fall_irq;
    evt.reset_req = compare_result;
    evt.kill_trig = compare_result;
  end

  assign CMP_IRQ = evt.irq;
  assign CMP_RESET_REQ = evt.reset_req;
  assign CMP_KILL_TRIG = evt.kill_trig;

endmodule

// ==== verif/cmpctl_checker.sv ====
/*
  Checker for the comparator control logic, watching only top-level ports.
  Assumes single-cycle register strobes and a level CMP_RAW from the analog side.
*/
`timescale 1ns/1ps
module cmpctl_checker (
  input wire logic CLK, // System clock
  input wire logic RST, // Asynchronous reset
  input wire logic [7:0] SFR_ADDR, // Register address
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic SFR_WE, // Write strobe
  input wire logic CMP_RAW, // Analog result
  input wire logic LATCHED_CMP_OUT, // Synchronous output
  input wire logic RAW_CMP_OUT, // Asynchronous output
  input wire logic [1:0] POS_HYST_SEL, // Positive hysteresis
  input wire logic [1:0] NEG_HYST_SEL, // Negative hysteresis
  input wire logic [1:0] RESPONSE_SPEED_SEL, // Response mode
  input wire logic CMP_POWER_EN, // Power enable
  input wire logic CMP_IRQ, // Interrupt request
  input wire logic CMP_RESET_REQ, // Reset request
  input wire logic CMP_KILL_TRIG // Kill trigger
);
  // ---------------------------------------------------------------
  // Helpers and sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic ctl_wr;
  logic mode_wr;
  logic wd_on;
  logic [3:0] wd_hyst;
  logic [1:0] wd_speed;
  // Write decode and data slices, so $past sees plain signals
  assign ctl_wr = SFR_WE && SFR_ADDR == cmpctl_pkg::CMPCTL_ADDR_CONTROL;
  assign mode_wr = SFR_WE && SFR_ADDR == cmpctl_pkg::CMPCTL_ADDR_MODE;
  assign wd_on = SFR_WDATA[7];
  assign wd_hyst = SFR_WDATA[3:0];
  assign wd_speed = SFR_WDATA[1:0];
  sequence rise_s;
    $rose(CMP_RAW) && CMP_POWER_EN;
  endsequence
  sequence held_s;
    CMP_RAW && CMP_POWER_EN;
  endsequence
  raw_gate_a: assert property (RAW_CMP_OUT == (CMP_RAW && CMP_POWER_EN))
    else $error("raw output differs from gated input");
  off_low_a: assert property (!CMP_POWER_EN && $past(!CMP_POWER_EN) |-> !LATCHED_CMP_OUT && !CMP_RESET_REQ)
    else $error("output high while disabled");
  kill_same_a: assert property (CMP_KILL_TRIG == CMP_RESET_REQ)
    else $error("kill trigger differs from reset request");
  sync_depth_a: assert property (rise_s ##1 held_s |-> !CMP_RESET_REQ)
    else $error("result passed fewer than two stages");
  latch_delay_a: assert property (rise_s ##1 held_s[*2] |-> !LATCHED_CMP_OUT && CMP_RESET_REQ ##1 LATCHED_CMP_OUT)
    else $error("latched output timing wrong");
  irq_cause_a: assert property ($rose(CMP_IRQ) |-> $past(SFR_WE) || $changed(LATCHED_CMP_OUT))
    else $error("interrupt rose without edge or write");
  irq_sticky_a: assert property ($fell(CMP_IRQ) |-> $past(SFR_WE))
    else $error("interrupt dropped without write");
  power_write_a: assert property ($past(ctl_wr) |-> CMP_POWER_EN == $past(wd_on))
    else $error("enable not loaded from write");
  hyst_write_a: assert property ($past(ctl_wr) |-> {POS_HYST_SEL, NEG_HYST_SEL} == $past(wd_hyst))
    else $error("hysteresis not loaded from write");
  speed_write_a: assert property ($past(mode_wr) |-> RESPONSE_SPEED_SEL == $past(wd_speed))
    else $error("response mode not loaded from write");
endmodule
bind cmpctl_top cmpctl_checker u_chk (.CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .SFR_WE(SFR_WE), .CMP_RAW(CMP_RAW), .LATCHED_CMP_OUT(LATCHED_CMP_OUT), .RAW_CMP_OUT(RAW_CMP_OUT),
  .POS_HYST_SEL(POS_HYST_SEL), .NEG_HYST_SEL(NEG_HYST_SEL), .RESPONSE_SPEED_SEL(RESPONSE_SPEED_SEL),
  .CMP_POWER_EN(CMP_POWER_EN), .CMP_IRQ(CMP_IRQ), .CMP_RESET_REQ(CMP_RESET_REQ), .CMP_KILL_TRIG(CMP_KILL_TRIG));

// ==== verif/cmpctl_analog_model.sv ====
/*
  Behavioural analog comparator standing behind the control logic.
  Assumes input voltages in millivolts set by the bench.
*/
`timescale 1ns/1ps
module cmpctl_analog_model (
  input wire logic power_en, // Analog power enable
  input wire integer pos_mv, // Positive input
  input wire integer neg_mv, // Negative input
  output logic cmp_raw // Comparison result
);
  // Unpowered stage gives the wrong level, so gating in the logic is exercised
  assign cmp_raw = power_en ? (pos_mv > neg_mv) : (pos_mv <= neg_mv);
endmodule

// ==== verif/test_cmpctl_top.sv ====
/*
  Self-checking bench for the comparator control logic.
  Assumes the analog model on CMP_RAW and registers at the package addresses.
*/
`timescale 1ns/1ps
module test_cmpctl_top;
  // ---------------------------------------------------------------
  // Signals, design and partner
  // ---------------------------------------------------------------
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} cmpctl_row_t;
  localparam logic [7:0] CTL = cmpctl_pkg::CMPCTL_ADDR_CONTROL;
  localparam logic [7:0] MODE = cmpctl_pkg::CMPCTL_ADDR_MODE;
  localparam cmpctl_row_t ROWS [10] = '{'{CTL, 8'h30, 8'h30}, '{CTL, 8'h41, 8'h01}, '{CTL, 8'h06, 8'h06},
    '{CTL, 8'h0b, 8'h0b}, '{CTL, 8'h0c, 8'h0c}, '{MODE, 8'hff, 8'h33}, '{MODE, 8'h00, 8'h00},
    '{MODE, 8'h01, 8'h01}, '{8'h9c, 8'hff, 8'h00}, '{MODE, 8'h02, 8'h02}};
  logic CLK = 1'b0, RST = 1'b1, SFR_WE = 1'b0, SFR_RE = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, rd;
  logic SFR_HIT, CMP_RAW, LATCHED_CMP_OUT, RAW_CMP_OUT, CMP_POWER_EN, CMP_IRQ, CMP_RESET_REQ, CMP_KILL_TRIG;
  logic [1:0] POS_HYST_SEL, NEG_HYST_SEL, RESPONSE_SPEED_SEL;
  int pos_mv = 0, neg_mv = 100, miscompares = 0, total_checks = 0, cycles = 0;
  cmpctl_top dut (.CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
    .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .CMP_RAW(CMP_RAW),
    .LATCHED_CMP_OUT(LATCHED_CMP_OUT), .RAW_CMP_OUT(RAW_CMP_OUT), .POS_HYST_SEL(POS_HYST_SEL),
    .NEG_HYST_SEL(NEG_HYST_SEL), .RESPONSE_SPEED_SEL(RESPONSE_SPEED_SEL), .CMP_POWER_EN(CMP_POWER_EN),
    .CMP_IRQ(CMP_IRQ), .CMP_RESET_REQ(CMP_RESET_REQ), .CMP_KILL_TRIG(CMP_KILL_TRIG));
  cmpctl_analog_model u_ana (.power_en(CMP_POWER_EN), .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(CMP_RAW));
  // 200 MHz clock; ceiling far above the hundred or so cycles the tests need
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  // Bus cycles: strobes raised after one edge, dropped after the sampling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WE <= 1'b1;
    @(posedge CLK);
    SFR_WE <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge CLK);
    SFR_ADDR <= a;
    SFR_RE <= 1'b1;
    @(posedge CLK);
    SFR_RE <= 1'b0;
    #1 rd = SFR_RDATA;
  endtask
  task cmp_in(input int p);
    @(posedge CLK);
    pos_mv <= p;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rdr(CTL);
    chk8(rd, 8'h00);
    rdr(MODE);
    chk8(rd, 8'h02);
    chk8({5'h00, RESPONSE_SPEED_SEL, CMP_POWER_EN}, 8'h04);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      wr(ROWS[i].addr, ROWS[i].wdata);
      rdr(ROWS[i].addr);
      chk8(rd, ROWS[i].rdata);
      chk1(SFR_HIT, ROWS[i].addr == CTL || ROWS[i].addr == MODE);
      if (ROWS[i].addr == CTL) chk8({4'h0, POS_HYST_SEL, NEG_HYST_SEL}, {4'h0, ROWS[i].wdata[3:0]});
      if (ROWS[i].addr == MODE) chk8({6'h00, RESPONSE_SPEED_SEL}, {6'h00, ROWS[i].wdata[1:0]});
    end
    $display("test table done");
    // Enable, clear spurious flags, then a rising edge
    wr(MODE, 8'h32);
    wr(CTL, 8'h80);
    repeat (4) @(posedge CLK);
    wr(CTL, 8'h80);
    rdr(CTL);
    chk8(rd, 8'h80);
    cmp_in(200);
    #1 chk8({6'h00, RAW_CMP_OUT, LATCHED_CMP_OUT}, 8'h02);
    repeat (4) @(posedge CLK);
    #1 chk8({4'h0, LATCHED_CMP_OUT, CMP_RESET_REQ, CMP_KILL_TRIG, CMP_IRQ}, 8'h0f);
    rdr(CTL);
    chk8(rd, 8'he0);
    // Falling edge lands on the same edge as a flag clear
    cmp_in(0);
    @(posedge CLK);
    wr(CTL, 8'h80);
    rdr(CTL);
    chk8(rd, 8'h90);
    chk1(CMP_IRQ, 1'b1);
    wr(MODE, 8'h22);
    #1 chk1(CMP_IRQ, 1'b0);
    cmp_in(200);
    repeat (5) @(posedge CLK);
    rdr(CTL);
    chk8(rd, 8'hf0);
    chk1(CMP_IRQ, 1'b1);
    $display("test edges done");
    // Disable while the unpowered model drives high
    cmp_in(0);
    wr(CTL, 8'h00);
    repeat (3) @(posedge CLK);
    #1 chk8({3'h0, RAW_CMP_OUT, LATCHED_CMP_OUT, CMP_RESET_REQ, CMP_POWER_EN, CMP_IRQ}, 8'h00);
    rdr(CTL);
    chk8({6'h00, rd[7:6]}, 8'h00);
    $display("test disable done");
    results();
  end
endmodule
